// ---- include/adbp_consts.svh ----
/*
 * Constants of the add/drop bus port: frame geometry, generated overhead
 * values, slot count and oscillator timing.
 * Assumes it is included by bare name wherever a figure is needed.
 */
`ifndef ADBP_CONSTS_SVH
`define ADBP_CONSTS_SVH

// sts-1 frame geometry for the generated frame
`define ADBP_COLS          7'd90
`define ADBP_ROWS          4'd9
`define ADBP_TOH_COLS      7'd3
`define ADBP_A1_COL        7'd0
`define ADBP_A2_COL        7'd1
`define ADBP_C1_COL        7'd2
`define ADBP_FRAME_ROW     4'd0
`define ADBP_PTR_ROW       4'd3
`define ADBP_H1_COL        7'd0
`define ADBP_H2_COL        7'd1
`define ADBP_J1_COL        7'd3

// generated transport overhead values, pointer of zero
`define ADBP_A1_VAL        8'hF6
`define ADBP_A2_VAL        8'h28
`define ADBP_C1_VAL        8'h01
`define ADBP_H1_VAL        8'h60
`define ADBP_H2_VAL        8'h00

// byte interleave of three tributaries
`define ADBP_LAST_SLOT     2'd2
`define ADBP_FIRST_AFTER_C1 2'd1

// line receive clock timing
`define ADBP_CORE_PERIOD_PS 10000
`define ADBP_DS3_PERIOD_PS 22350
`define ADBP_E3_PERIOD_PS  29100
`define ADBP_DS3_CYC       ((`ADBP_DS3_PERIOD_PS + `ADBP_CORE_PERIOD_PS - 1) / `ADBP_CORE_PERIOD_PS)
`define ADBP_E3_CYC        ((`ADBP_E3_PERIOD_PS + `ADBP_CORE_PERIOD_PS - 1) / `ADBP_CORE_PERIOD_PS)
`define ADBP_STALL_MARGIN  2

`endif

// ---- include/adbp_pkg.sv ----
/*
 * Types of the add/drop bus port: bus format and insert timing source.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package adbp_pkg;

	// bus format on the drop and add buses
	typedef enum logic [2:0] {
		FMT_STM1 = 3'b001,
		FMT_STS3 = 3'b010,
		FMT_STS1 = 3'b100
	} adbp_fmt_t;

	// where the insert bus byte timing comes from
	typedef enum logic [2:0] {
		TSRC_INSERT   = 3'b001,
		TSRC_EXTRACT  = 3'b010,
		TSRC_EXTERNAL = 3'b100
	} adbp_tsrc_t;

endpackage

// ---- include/adbp_sync_if.sv ----
/*
 * Carrier from a pin synchroniser to the port logic: settled level and
 * one-cycle edge pulses of bit zero.
 * Assumes both ends run on core_clk.
 */
`timescale 1ns/100ps
interface adbp_sync_if #(parameter int W = 1);
	logic [W-1:0] level;
	logic         rise;
	logic         fall;
	modport src (output level, output rise, output fall);
	modport dst (input level, input rise, input fall);
endinterface

// ---- hw/adbp_pin_sync.sv ----
/*
 * Three-stage pin synchroniser with agreement filter and edge pulses.
 * Assumes pins are asynchronous to core_clk and change slower than it.
 */
`timescale 1ns/100ps
module adbp_pin_sync #(parameter int W = 1) (
	// clock and reset
	input  wire logic         core_clk,
	input  wire logic         sys_rst,
	// pin side
	input  wire logic [W-1:0] pinIn,
	// settled side
	adbp_sync_if.src          syncOut
);
	logic [W-1:0] s1_reg, s2_reg, s3_reg, stable_reg;
	logic [W-1:0] s1_next, s2_next, s3_next, stable_next;
	logic         rise_reg, fall_reg, rise_next, fall_next;

	// a change counts once stages two and three agree
	always_comb begin
		s1_next = pinIn;
		s2_next = s1_reg;
		s3_next = s2_reg;
		stable_next = (s2_reg == s3_reg) ? s3_reg : stable_reg;
		rise_next = ~stable_reg[0] & stable_next[0];
		fall_next = stable_reg[0] & ~stable_next[0];
	end

	// registers only
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s1_reg     <= '0;
			s2_reg     <= '0;
			s3_reg     <= '0;
			stable_reg <= '0;
			rise_reg   <= 1'b0;
			fall_reg   <= 1'b0;
		end else begin
			s1_reg     <= s1_next;
			s2_reg     <= s2_next;
			s3_reg     <= s3_next;
			stable_reg <= stable_next;
			rise_reg   <= rise_next;
			fall_reg   <= fall_next;
		end
	end

	assign syncOut.level = stable_reg;
	assign syncOut.rise  = rise_reg;
	assign syncOut.fall  = fall_reg;
endmodule

// ---- hw/adbp_port.sv ----
/*
 * Add/drop bus port: drop-side byte capture, add-side slot insertion in
 * derived or external timing, and the line receive clock.
 * Assumes bus clocks far below core_clk and static mode inputs.
 */
// Operation
// RULE1: stm-1 single j1 marks vc-4 start
// RULE2: sts-3 carries three j1 pulses, one each
// RULE3: sts-1 uses its single j1 marker
// RULE4: stm-1 tributary b one byte after a
// RULE5: sts-3 second slot one byte later
// RULE6: derived timing: data one byte after markers
// RULE7: sample insert markers on byte clock fall
// RULE8: change insert outputs on byte clock rise
// RULE9: outside slot: release data, slot high
// RULE10: capture extract bus on clock fall
// RULE11: unused c1-only input tied low outside
// RULE12: external clock mode sends pointer zero
// RULE13: overhead bit generates a1 a2 c1 h1 h2
// RULE14: external mode markers aligned with data
// RULE15: receive clock derived from oscillator input
// RULE16: receive clock period per ds3 or e3; the stall limit is 6 core cycles for both
// RULE17: slot low only own bytes, even parity
`timescale 1ns/100ps
`include "adbp_consts.svh"
module adbp_port (
	// clock and reset
	input  wire logic               core_clk,
	input  wire logic               sys_rst,
	// static configuration
	input  wire adbp_pkg::adbp_fmt_t  busFormat,
	input  wire adbp_pkg::adbp_tsrc_t timingSource,
	input  wire logic [1:0]         tribSelect,
	input  wire logic               transportOverheadGenerate,
	input  wire logic               tribFormatE3,
	// tributary bytes to insert
	input  wire logic [7:0]         tribData,
	output logic                    tribTake,
	// insert bus clock pin and external byte clock
	input  wire logic               insertBusClockIn,
	output logic                    insertBusClockOut,
	output logic                    insertBusClockOe,
	input  wire logic               extClockIn,
	// insert bus markers, two-way
	input  wire logic               insertFrameMarkerIn,
	output logic                    insertFrameMarkerOut,
	output logic                    insertFrameMarkerOe,
	input  wire logic               insertPayloadEnvelopeIn,
	output logic                    insertPayloadEnvelopeOut,
	output logic                    insertPayloadEnvelopeOe,
	// insert bus data and slot indicator
	output logic [7:0]              insertBusDataOut,
	output logic                    insertBusDataOe,
	output logic                    insertBusParityOut,
	output logic                    insertBusParityOe,
	output logic                    insertSlotN,
	// extract bus
	input  wire logic               extractBusClock,
	input  wire logic [7:0]         extractBusData,
	input  wire logic               extractBusParity,
	input  wire logic               extractFrameMarker,
	input  wire logic               extractC1OnlyMarker,
	input  wire logic               extractPayloadEnvelope,
	// dropped bytes
	output logic [7:0]              dropData,
	output logic                    dropValid,
	output logic                    dropParityErr,
	output logic                    dropFrameStart,
	output logic                    dropC1,
	// line receive clock
	input  wire logic               oscillatorInput,
	output logic                    lineRxClock,
	output logic                    rxClockStall
);
	import adbp_pkg::*;

	adbp_sync_if #(.W(1))  insClkIf ();
	adbp_sync_if #(.W(1))  extClkIf ();
	adbp_sync_if #(.W(1))  drpClkIf ();
	adbp_sync_if #(.W(1))  oscIf ();
	adbp_sync_if #(.W(2))  insCtlIf ();
	adbp_sync_if #(.W(12)) drpBusIf ();

	// every pin crosses four flops before use
	adbp_pin_sync #(.W(1)) uInsClk (.core_clk(core_clk), .sys_rst(sys_rst),
		.pinIn(insertBusClockIn), .syncOut(insClkIf.src));
	adbp_pin_sync #(.W(1)) uExtClk (.core_clk(core_clk), .sys_rst(sys_rst),
		.pinIn(extClockIn), .syncOut(extClkIf.src));
	adbp_pin_sync #(.W(1)) uDrpClk (.core_clk(core_clk), .sys_rst(sys_rst),
		.pinIn(extractBusClock), .syncOut(drpClkIf.src));
	adbp_pin_sync #(.W(1)) uOsc (.core_clk(core_clk), .sys_rst(sys_rst),
		.pinIn(oscillatorInput), .syncOut(oscIf.src));
	adbp_pin_sync #(.W(2)) uInsCtl (.core_clk(core_clk), .sys_rst(sys_rst),
		.pinIn({insertFrameMarkerIn, insertPayloadEnvelopeIn}), .syncOut(insCtlIf.src));
	adbp_pin_sync #(.W(12)) uDrpBus (.core_clk(core_clk), .sys_rst(sys_rst),
		.pinIn({extractBusData, extractBusParity, extractFrameMarker,
			extractPayloadEnvelope, extractC1OnlyMarker}),
		.syncOut(drpBusIf.src));

	// settled extract bus fields, same delay as its clock
	logic [7:0] dBusData;
	logic       dBusPar, dBusMark, dBusSpe, dBusC1;
	assign dBusData = drpBusIf.level[11:4];
	assign dBusPar  = drpBusIf.level[3];
	assign dBusMark = drpBusIf.level[2];
	assign dBusSpe  = drpBusIf.level[1];
	assign dBusC1   = drpBusIf.level[0];

	// drop side: capture on falling byte clock, select own tributary
	logic [1:0] dPhase_reg, dPhase_next, dCur;
	logic [7:0] dropData_reg, dropData_next;
	logic       dropValid_reg, dropValid_next, dropParityErr_reg, dropParityErr_next;
	logic       dropFrameStart_reg, dropFrameStart_next, dropC1_reg, dropC1_next;
	logic       dIsC1, dIsJ1, dOwn;

	always_comb begin
		dIsC1 = (dBusMark & ~dBusSpe) | dBusC1;
		dIsJ1 = dBusMark & dBusSpe;
		dCur = dIsC1 ? 2'd0 : dPhase_reg;
		dOwn = (busFormat == FMT_STS1) | (dCur == tribSelect);
		dPhase_next = dPhase_reg;
		dropData_next = dropData_reg;
		dropValid_next = 1'b0;
		dropParityErr_next = 1'b0;
		dropFrameStart_next = 1'b0;
		dropC1_next = 1'b0;
		if (drpClkIf.fall) begin // RULE10
			dPhase_next = (dCur == `ADBP_LAST_SLOT) ? 2'd0 : dCur + 2'd1;
			dropC1_next = dIsC1;
			if (dBusSpe && dOwn) begin
				dropData_next = dBusData;
				dropValid_next = 1'b1;
				dropParityErr_next = (^dBusData) != dBusPar;
			end
			unique case (busFormat)
				FMT_STM1: dropFrameStart_next = dIsJ1; // RULE1
				FMT_STS3: dropFrameStart_next = dIsJ1 & (dCur == tribSelect); // RULE2
				FMT_STS1: dropFrameStart_next = dIsJ1; // RULE3
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dPhase_reg         <= 2'h0;
			dropData_reg       <= 8'h00;
			dropValid_reg      <= 1'b0;
			dropParityErr_reg  <= 1'b0;
			dropFrameStart_reg <= 1'b0;
			dropC1_reg         <= 1'b0;
		end else begin
			dPhase_reg         <= dPhase_next;
			dropData_reg       <= dropData_next;
			dropValid_reg      <= dropValid_next;
			dropParityErr_reg  <= dropParityErr_next;
			dropFrameStart_reg <= dropFrameStart_next;
			dropC1_reg         <= dropC1_next;
		end
	end

	// derived timing source for the insert side
	logic bFall, bRise, bMark, bSpe, bC1, extMode;
	always_comb begin
		extMode = (timingSource == TSRC_EXTERNAL);
		// idle values first, so an illegal source code cannot latch
		bFall = 1'b0;
		bRise = 1'b0;
		bMark = 1'b0;
		bSpe  = 1'b0;
		bC1   = 1'b0;
		unique case (timingSource)
			TSRC_INSERT: begin
				bFall = insClkIf.fall;
				bRise = insClkIf.rise;
				bMark = insCtlIf.level[1];
				bSpe  = insCtlIf.level[0];
				bC1   = 1'b0;
			end
			TSRC_EXTRACT: begin
				bFall = drpClkIf.fall;
				bRise = drpClkIf.rise;
				bMark = dBusMark;
				bSpe  = dBusSpe;
				bC1   = dBusC1; // RULE11
			end
			TSRC_EXTERNAL: ; // own frame counter, no derived timing
		endcase
	end

	// derived insert: markers taken on fall, slot decided for next byte
	logic [1:0] aPhase_reg, aPhase_next, aCur;
	logic       pendHit_reg, pendHit_next;
	always_comb begin
		aCur = ((bMark & ~bSpe) | bC1) ? 2'd0 : aPhase_reg;
		aPhase_next = aPhase_reg;
		pendHit_next = pendHit_reg;
		if (bFall) begin // RULE7
			aPhase_next = (aCur == `ADBP_LAST_SLOT) ? 2'd0 : aCur + 2'd1;
			// slot b, c, a fall on consecutive bytes after c1
			pendHit_next = bSpe & ((busFormat == FMT_STS1) | (aCur == tribSelect)); // RULE4 RULE5
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			aPhase_reg  <= `ADBP_FIRST_AFTER_C1;
			pendHit_reg <= 1'b0;
		end else begin
			aPhase_reg  <= aPhase_next;
			pendHit_reg <= pendHit_next;
		end
	end

	// external clock mode: own sts-1 frame counter
	logic [6:0] col_reg, col_next, nCol;
	logic [3:0] row_reg, row_next, nRow;
	logic       xA1, xA2, xC1, xH1, xH2, xSpe, xJ1, xOh;
	logic [7:0] xOhByte;
	always_comb begin
		nCol = (col_reg == `ADBP_COLS - 7'd1) ? 7'd0 : col_reg + 7'd1;
		nRow = row_reg;
		if (col_reg == `ADBP_COLS - 7'd1)
			nRow = (row_reg == `ADBP_ROWS - 4'd1) ? 4'd0 : row_reg + 4'd1;
		col_next = col_reg;
		row_next = row_reg;
		if (extMode && extClkIf.rise) begin
			col_next = nCol;
			row_next = nRow;
		end
		xA1 = (nRow == `ADBP_FRAME_ROW) && (nCol == `ADBP_A1_COL);
		xA2 = (nRow == `ADBP_FRAME_ROW) && (nCol == `ADBP_A2_COL);
		xC1 = (nRow == `ADBP_FRAME_ROW) && (nCol == `ADBP_C1_COL);
		xH1 = (nRow == `ADBP_PTR_ROW) && (nCol == `ADBP_H1_COL);
		xH2 = (nRow == `ADBP_PTR_ROW) && (nCol == `ADBP_H2_COL);
		// pointer zero puts j1 right after h3
		xJ1 = (nRow == `ADBP_PTR_ROW) && (nCol == `ADBP_J1_COL); // RULE12
		xSpe = nCol >= `ADBP_TOH_COLS;
		xOh = transportOverheadGenerate & (xA1 | xA2 | xC1 | xH1 | xH2); // RULE13
		xOhByte = `ADBP_H2_VAL; // RULE12
		if (xA1)
			xOhByte = `ADBP_A1_VAL;
		else if (xA2)
			xOhByte = `ADBP_A2_VAL;
		else if (xC1)
			xOhByte = `ADBP_C1_VAL;
		else if (xH1)
			xOhByte = `ADBP_H1_VAL;
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			col_reg <= `ADBP_COLS - 7'd1;
			row_reg <= `ADBP_ROWS - 4'd1;
		end else begin
			col_reg <= col_next;
			row_reg <= row_next;
		end
	end

	// insert bus data, parity, slot and markers change on a rising byte clock; the clock output follows extClockIn in external mode, low otherwise
	logic [7:0] insert_bus_data_reg, insert_bus_data_next;
	logic       aDataOe_reg, aDataOe_next, insert_bus_parity_reg, insert_bus_parity_next, aSlotN_reg, aSlotN_next;
	logic       mOut_reg, mOut_next, sOut_reg, sOut_next, mOe_reg, mOe_next;
	logic       cOut_reg, cOut_next, cOe_reg, cOe_next, take_reg, take_next;
	always_comb begin
		insert_bus_data_next = insert_bus_data_reg;
		aDataOe_next = aDataOe_reg;
		insert_bus_parity_next = insert_bus_parity_reg;
		aSlotN_next = aSlotN_reg;
		mOut_next = mOut_reg;
		sOut_next = sOut_reg;
		mOe_next = extMode;
		cOe_next = extMode;
		cOut_next = extMode & extClkIf.level[0];
		take_next = 1'b0;
		if (!extMode) begin
			mOut_next = 1'b0;
			sOut_next = 1'b0;
		end
		if (extMode && extClkIf.rise) begin // RULE8
			// markers and data of the same byte leave together
			mOut_next = xC1 | xJ1; // RULE14
			sOut_next = xSpe; // RULE14
			insert_bus_data_next = xOh ? xOhByte : tribData;
			insert_bus_parity_next = xOh ? ^xOhByte : ^tribData; // RULE17
			aDataOe_next = xSpe | xOh;
			aSlotN_next = ~(xSpe | xOh); // RULE17
			take_next = xSpe;
		end else if (!extMode && bRise) begin // RULE8
			// byte marked on the last fall goes out now
			insert_bus_data_next = pendHit_reg ? tribData : insert_bus_data_reg; // RULE6
			insert_bus_parity_next = pendHit_reg ? ^tribData : insert_bus_parity_reg; // RULE17
			aDataOe_next = pendHit_reg; // RULE9
			aSlotN_next = ~pendHit_reg; // RULE9 RULE17
			take_next = pendHit_reg;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			insert_bus_data_reg   <= 8'h00;
			aDataOe_reg <= 1'b0;
			insert_bus_parity_reg    <= 1'b0;
			aSlotN_reg  <= 1'b1;
			mOut_reg    <= 1'b0;
			sOut_reg    <= 1'b0;
			mOe_reg     <= 1'b0;
			cOut_reg    <= 1'b0;
			cOe_reg     <= 1'b0;
			take_reg    <= 1'b0;
		end else begin
			insert_bus_data_reg   <= insert_bus_data_next;
			aDataOe_reg <= aDataOe_next;
			insert_bus_parity_reg    <= insert_bus_parity_next;
			aSlotN_reg  <= aSlotN_next;
			mOut_reg    <= mOut_next;
			sOut_reg    <= sOut_next;
			mOe_reg     <= mOe_next;
			cOut_reg    <= cOut_next;
			cOe_reg     <= cOe_next;
			take_reg    <= take_next;
		end
	end

	// receive clock follows the oscillator; no oscillator rise for over 6 core cycles flags a stall
	logic       rxClk_reg, rxClk_next, stall_reg, stall_next;
	logic [3:0] oscCnt_reg, oscCnt_next, oscLimit;
	always_comb begin
		oscLimit = tribFormatE3 ? 4'(`ADBP_E3_CYC * `ADBP_STALL_MARGIN) // RULE16
			: 4'(`ADBP_DS3_CYC * `ADBP_STALL_MARGIN);
		rxClk_next = oscIf.level[0]; // RULE15
		oscCnt_next = oscIf.rise ? 4'h0 : oscCnt_reg + {3'h0, (oscCnt_reg != 4'hF)};
		stall_next = oscCnt_reg > oscLimit; // RULE16
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rxClk_reg  <= 1'b0;
			oscCnt_reg <= 4'h0;
			stall_reg  <= 1'b0;
		end else begin
			rxClk_reg  <= rxClk_next;
			oscCnt_reg <= oscCnt_next;
			stall_reg  <= stall_next;
		end
	end

	// outputs straight from flops
	assign tribTake                 = take_reg;
	assign insertBusClockOut        = cOut_reg;
	assign insertBusClockOe         = cOe_reg;
	assign insertFrameMarkerOut     = mOut_reg;
	assign insertFrameMarkerOe      = mOe_reg;
	assign insertPayloadEnvelopeOut = sOut_reg;
	assign insertPayloadEnvelopeOe  = mOe_reg;
	assign insertBusDataOut         = insert_bus_data_reg;
	assign insertBusDataOe          = aDataOe_reg;
	assign insertBusParityOut       = insert_bus_parity_reg;
	assign insertBusParityOe        = aDataOe_reg;
	assign insertSlotN              = aSlotN_reg;
	assign dropData                 = dropData_reg;
	assign dropValid                = dropValid_reg;
	assign dropParityErr            = dropParityErr_reg;
	assign dropFrameStart           = dropFrameStart_reg;
	assign dropC1                   = dropC1_reg;
	assign lineRxClock              = rxClk_reg;
	assign rxClockStall             = stall_reg;
endmodule

// ---- tb/adbp_port_checker.sv ----
/*
 * Concurrent checks on the add/drop bus port top ports.
 * Assumes one core_clk domain and sys_rst asynchronous, active high.
 */
`timescale 1ns/100ps
module adbp_port_checker (
	// clock and reset
	input wire logic                core_clk,
	input wire logic                sys_rst,
	// mode and tributary side
	input wire adbp_pkg::adbp_tsrc_t timingSource,
	input wire adbp_pkg::adbp_fmt_t  busFormat,
	input wire logic [7:0]          tribData,
	input wire logic                tribTake,
	// insert bus
	input wire logic                extractBusClock,
	input wire logic [7:0]          insertBusDataOut,
	input wire logic                insertBusDataOe,
	input wire logic                insertBusParityOut,
	input wire logic                insertBusParityOe,
	input wire logic                insertSlotN,
	input wire logic                insertFrameMarkerOut,
	input wire logic                insertFrameMarkerOe,
	// drop side and receive clock
	input wire logic                dropValid,
	input wire logic                dropParityErr,
	input wire logic                dropFrameStart,
	input wire logic                oscillatorInput,
	input wire logic                lineRxClock,
	input wire logic                rxClockStall
);
	import adbp_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// oscillator quiet spans, and the derived byte clock falling
	sequence s_osc_low;
		(!oscillatorInput) [*8];
	endsequence
	sequence s_osc_dead;
		s_osc_low ##1 s_osc_low;
	endsequence
	sequence s_add_fall;
		(timingSource == TSRC_EXTRACT) && $fell(extractBusClock);
	endsequence
	// insert bus drive, parity and slot indicator agree
	a_parity_even: assert property (insertBusDataOe |-> insertBusParityOut == ^insertBusDataOut)
		else $error("insert parity not even");
	a_parity_oe_tied: assert property (insertBusParityOe == insertBusDataOe)
		else $error("parity enable differs from data enable");
	a_slot_marks_drive: assert property (timingSource != TSRC_EXTERNAL
		|-> insertSlotN == !insertBusDataOe)
		else $error("slot indicator and data enable disagree");
	a_take_gives_byte: assert property (tribTake
		|-> insertBusDataOe && insertBusDataOut == $past(tribData))
		else $error("taken byte not on insert bus");
	a_take_one_cycle: assert property (tribTake |=> !tribTake)
		else $error("take pulse longer than one cycle");
	a_marker_idle: assert property (timingSource != TSRC_EXTERNAL
		|-> !insertFrameMarkerOe && !insertFrameMarkerOut)
		else $error("marker driven outside external timing");
	// slot indicator holds for four cycles after the byte clock falls
	a_slot_holds_fall: assert property (s_add_fall |=> $stable(insertSlotN) [*4])
		else $error("slot indicator moved after byte clock fall");
	// drop parity error pulses come with a valid byte
	a_err_with_valid: assert property (dropParityErr |-> dropValid)
		else $error("parity error without byte");
	// stm-1 start marks the shared vc-4, which may open in another slot
	a_start_with_valid: assert property (busFormat != FMT_STM1 && dropFrameStart
		|-> dropValid)
		else $error("frame start without byte");
	// receive clock tracks the oscillator pin
	a_rx_follows_osc: assert property (s_osc_low |-> !lineRxClock)
		else $error("receive clock high with oscillator quiet");
	a_rx_stall_flag: assert property (s_osc_dead |-> rxClockStall)
		else $error("stall not flagged on dead oscillator");
endmodule
bind adbp_port adbp_port_checker i_chk (.core_clk, .sys_rst, .timingSource, .busFormat, .tribData,
	.tribTake, .extractBusClock, .insertBusDataOut, .insertBusDataOe, .insertBusParityOut,
	.insertBusParityOe, .insertSlotN, .insertFrameMarkerOut, .insertFrameMarkerOe,
	.dropValid, .dropParityErr, .dropFrameStart, .oscillatorInput, .lineRxClock,
	.rxClockStall);

// ---- tb/adbp_bus_model.sv ----
/*
 * Byte bus partner: framer side of the drop bus, also feeding the
 * insert markers; records the port's insert output per byte.
 * Assumes core_clk far faster than the byte clock it makes.
 */
`timescale 1ns/100ps
module adbp_bus_model (
	// clock
	input wire logic       core_clk,
	// byte bus toward the port
	output logic           busClock,
	output logic [7:0]     busData,
	output logic           busParity,
	output logic           busMarker,
	output logic           busEnvelope,
	output logic           busC1Only,
	// insert output seen back
	input wire logic       slotN,
	input wire logic       addOe,
	input wire logic [7:0] addData
);
	logic [8:0] seen[$];
	// clock stands low between frames
	initial begin
		busClock = 1'b0;
		busData = 8'h5A;
		busParity = 1'b0;
		busMarker = 1'b0;
		busEnvelope = 1'b0;
		busC1Only = 1'b0;
	end
	// fields launched at the rise, held well past the fall
	task automatic put(input logic [7:0] d, input logic m, input logic e, input logic bad);
		@(posedge core_clk);
		busClock <= 1'b1;
		busData <= d;
		busParity <= ^d ^ bad;
		busMarker <= m;
		busEnvelope <= e;
		repeat (6) @(posedge core_clk);
		busClock <= 1'b0;
		repeat (5) @(posedge core_clk);
		// a released data bus floats to its pull-up level
		seen.push_back({slotN, addOe ? addData : 8'hFF});
	endtask
	// released bus shows no stale byte
	task automatic rest();
		@(posedge core_clk);
		busData <= ~busData;
		busParity <= ~busParity;
		busMarker <= 1'b0;
		busEnvelope <= 1'b0;
	endtask
endmodule

// ---- tb/adbp_port_bench.sv ----
/*
 * Bench of the add/drop bus port: drop and derived insert per format,
 * external timing frame, and the line receive clock.
 * Assumes the bus model stands on both extract and insert pins.
 */
`timescale 1ns/100ps
module adbp_port_bench;
	import adbp_pkg::*;
	logic core_clk, sys_rst, ohGen, tribFormatE3, extClock, osc, tribTake, clkOut, clkOe;
	logic fmOut, fmOe, peOut, peOe, dataOe, parOut, parOe, slotN, dropValid, perr, fstart;
	logic rxClk, stall, busClk, busMarker, busEnv, busPar, busC1, c1;
	logic [7:0] tribData, dataOut, dropData, busData;
	logic [1:0] sel;
	adbp_fmt_t  fmt;
	adbp_tsrc_t tsrc;
	int n_fail, n_checks, nTake, nErr, nStart, nC1, cycles;
	logic [7:0] drops[$];
	// 100 MHz core clock
	always #5 core_clk = ~core_clk;
	adbp_port i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .busFormat(fmt),
		.timingSource(tsrc), .tribSelect(sel), .transportOverheadGenerate(ohGen),
		.tribFormatE3(tribFormatE3), .tribData(tribData), .tribTake(tribTake),
		.insertBusClockIn(clkOe ? clkOut : busClk), .insertBusClockOut(clkOut),
		.insertBusClockOe(clkOe), .extClockIn(extClock),
		.insertFrameMarkerIn(fmOe ? fmOut : busMarker), .insertFrameMarkerOut(fmOut),
		.insertFrameMarkerOe(fmOe), .insertPayloadEnvelopeIn(peOe ? peOut : busEnv),
		.insertPayloadEnvelopeOut(peOut), .insertPayloadEnvelopeOe(peOe),
		.insertBusDataOut(dataOut), .insertBusDataOe(dataOe), .insertBusParityOut(parOut),
		.insertBusParityOe(parOe), .insertSlotN(slotN), .extractBusClock(busClk),
		.extractBusData(busData), .extractBusParity(busPar), .extractFrameMarker(busMarker),
		.extractC1OnlyMarker(busC1), .extractPayloadEnvelope(busEnv), .dropData(dropData),
		.dropValid(dropValid), .dropParityErr(perr), .dropFrameStart(fstart), .dropC1(c1),
		.oscillatorInput(osc), .lineRxClock(rxClk), .rxClockStall(stall));
	adbp_bus_model i_model (.core_clk(core_clk), .busClock(busClk), .busData(busData),
		.busParity(busPar), .busMarker(busMarker), .busEnvelope(busEnv), .busC1Only(busC1),
		.slotN(slotN), .addOe(dataOe), .addData(dataOut));
	task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// modes are static, so every change goes through reset
	task automatic restart(input adbp_fmt_t f, input adbp_tsrc_t t, input logic [1:0] s);
		@(posedge core_clk);
		sys_rst <= 1'b1;
		fmt <= f;
		tsrc <= t;
		sel <= s;
		repeat (10) @(posedge core_clk);
		sys_rst <= 1'b0;
		repeat (6) @(posedge core_clk);
		drops.delete();
		i_model.seen.delete();
		nTake = 0;
		nErr = 0;
		nStart = 0;
		nC1 = 0;
	endtask
	// c1 byte, six envelope bytes with a bad parity on the fourth, one idle byte
	task automatic run_frame(input adbp_fmt_t f, input adbp_tsrc_t t, input logic [1:0] s);
		logic hit [8];
		logic mark;
		int nHit;
		logic [7:0] want[$];
		restart(f, t, s);
		nHit = 0;
		for (int k = 0; k < 8; k++) begin
			hit[k] = k > 0 && k < 7 && (f == FMT_STS1 || k % 3 == s);
			if (hit[k]) want.push_back(8'(k * 19));
			nHit += hit[k];
			mark = k < 2 || (k < 4 && f == FMT_STS3);
			i_model.put(8'(k * 19), mark, k > 0 && k < 7, k == 4);
		end
		i_model.rest();
		repeat (8) @(posedge core_clk);
		chk("drop count", drops.size(), want.size());
		foreach (want[i]) chk("drop byte", drops[i], want[i]);
		chk("parity errors", nErr, hit[4]);
		chk("frame starts", nStart, 1);
		chk("c1 pulses", nC1, 1);
		chk("takes", nTake, nHit);
		for (int k = 1; k < 8; k++) begin
			chk("slot", i_model.seen[k], hit[k-1] ? {1'b0, tribData} : {1'b1, 8'hFF});
		end
		$display("frame test format %0d done", f);
	endtask
	// external clock: generated overhead, pointer zero, aligned markers
	task automatic run_external();
		logic [10:0] got;
		restart(FMT_STS1, TSRC_EXTERNAL, 2'd0);
		for (int n = 0; n < 274; n++) begin
			extClock <= 1'b1;
			repeat (5) @(posedge core_clk);
			extClock <= 1'b0;
			repeat (4) @(posedge core_clk);
			got = {dataOe, fmOut, peOut, dataOut};
			case (n)
				0: chk("a1", got, 11'h4F6);
				1: chk("a2", got, 11'h428);
				2: chk("c1", got, 11'h601);
				3: chk("payload", got, 11'h53C);
				270: chk("h1", got, 11'h460);
				271: chk("h2", got, 11'h400);
				273: chk("j1", got, 11'h73C);
				default: ;
			endcase
			@(posedge core_clk);
		end
		$display("external timing test done");
	endtask
	// ten oscillator rises, then a dead oscillator
	task automatic run_rxclock(input logic e3);
		int rises;
		logic last;
		tribFormatE3 <= e3;
		restart(FMT_STS1, TSRC_EXTRACT, 2'd0);
		rises = 0;
		last = rxClk;
		for (int n = 0; n < 80; n++) begin
			@(posedge core_clk);
			osc <= n < 60 && n % 6 < 3;
			rises += rxClk && !last;
			last = rxClk;
			if (n == 50) chk("rx running", stall, 1'b0);
		end
		chk("rx rises", rises, 10);
		chk("rx stall", stall, 1'b1);
		$display("receive clock test e3=%0d done", e3);
	endtask
	// drop monitor and run limit, sampled on the quiet edge
	always @(negedge core_clk) begin
		cycles++;
		if (dropValid === 1'b1) drops.push_back(dropData);
		nErr += perr;
		nStart += fstart;
		nC1 += c1;
		nTake += tribTake;
		if (cycles == 10000) begin
			n_fail++;
			results();
		end
	end
	initial begin
		core_clk = 1'b0;
		sys_rst = 1'b1;
		fmt = FMT_STS1;
		tsrc = TSRC_EXTRACT;
		sel = 2'd0;
		ohGen = 1'b1;
		tribFormatE3 = 1'b0;
		tribData = 8'h3C;
		extClock = 1'b0;
		osc = 1'b0;
		run_frame(FMT_STM1, TSRC_INSERT, 2'd2);
		run_frame(FMT_STS3, TSRC_EXTRACT, 2'd1);
		run_frame(FMT_STS1, TSRC_EXTRACT, 2'd0);
		run_external();
		run_rxclock(1'b0);
		run_rxclock(1'b1);
		results();
	end
endmodule
